// [core/ccr_top.sv]
// Behaviour
// - a one written to bit 7 of the current register enters charger reset; a zero does nothing.
// - bit 7 of the current register always reads back as one.
// - bits 6..4 set fast-charge sense voltage 37.4 mV plus 27.2/13.6/6.8 mV, default zero.
// - bits 2..0 set termination sense voltage 3.4 mV plus 13.6/6.8/3.4 mV, default 001.
// - reset loads the current register with 89h.
// - the identification register carries a read-only 3-bit revision in bits 2..0.
// - after termination, a battery below the refresh threshold starts a new charge cycle.
// - below the short-circuit threshold the charge current is clamped to the short limit.
// - the safety timer always runs while charging; expiry stops charging, and marks the battery defective only in precharge.
// - writing one to bit 7 of the status register restarts the safety timer; it self-clears.
`timescale 1ns/1ps
`default_nettype none
module ccr_top #(
    parameter logic [6:0]  DEV_ADDR    = 7'h6a,
    // arbitrary identity values
    parameter logic [2:0]  VENDOR_CODE = 3'h0,
    parameter logic [1:0]  PART_CODE   = 2'h0,
    parameter logic [2:0]  REV_CODE    = 3'h2,
    parameter int unsigned MS_CYC      = ccr_pkg::MS_CYCLES,
    parameter int unsigned SAFE_MS     = ccr_pkg::SAFETY_MS
) (
    // clock and reset
    input  wire logic            clock,
    input  wire logic            sys_rst,
    // serial bus pins
    input  wire logic            scl_pin,
    input  wire logic            sda_pin,
    output logic                 sda_out,
    output logic                 sda_oe,
    // comparators from the analog stage
    input  wire ccr_pkg::ccr_sense_s sense_pin,
    // power stage controls
    output logic [9:0]           fast_sense_lvl,
    output logic [9:0]           end_sense_lvl,
    output logic                 charge_on,
    output logic                 short_clamp,
    output logic                 charger_reset,
    output logic                 battery_defective,
    output logic [1:0]           charge_stat
);
    import ccr_pkg::*;

    if (MS_CYC < 1 || MS_CYC > 32768 || SAFE_MS < 1 || SAFE_MS > 2097151) begin : g_chk
        $error("ccr_top: timer parameters out of range");
    end

    // level for a 3-bit binary weighted code
    function automatic logic [9:0] sense_level(input logic [9:0] base,
                                               input logic [9:0] step,
                                               input logic [2:0] code);
        sense_level = base + 10'(step * {7'h00, code});
    endfunction

    // serial bus slave
    ccr_regbus_s bus;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic        slv_oe;

    ccr_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_slave (
        .clock   (clock),
        .sys_rst (sys_rst),
        .scl_pin (scl_pin),
        .sda_pin (sda_pin),
        .sda_oe  (slv_oe),
        .rd_data (rd_data),
        .rd_addr (rd_addr),
        .bus     (bus)
    );

    // comparator synchronisers
    ccr_sense_s s1_ff, s2_ff;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else begin
            s1_ff <= sense_pin;
            s2_ff <= s1_ff;
        end
    end

    // register file
    logic [6:0] cur_ff, nxt_cur;
    logic       crst_ff, nxt_crst;
    logic       tmr_req_ff, nxt_tmr_req;
    logic       wr_cur, wr_stat;

    assign wr_cur  = bus.wr_stb && bus.wr_addr == ADDR_CURRENT;
    assign wr_stat = bus.wr_stb && bus.wr_addr == ADDR_STATCTL;

    always_comb begin
        nxt_cur     = cur_ff;
        nxt_crst    = 1'b0;
        nxt_tmr_req = 1'b0;
        if (wr_cur) begin
            if (bus.wr_data[CUR_RESET_B]) begin
                nxt_crst = 1'b1;
                nxt_cur  = CUR_RST[6:0];
            end else begin
                nxt_cur  = bus.wr_data[6:0];
            end
        end
        if (wr_stat && bus.wr_data[TIMER_RESTART_B]) begin
            nxt_tmr_req = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff     <= CUR_RST[6:0];
            crst_ff    <= 1'b0;
            tmr_req_ff <= 1'b0;
        end else begin
            cur_ff     <= nxt_cur;
            crst_ff    <= nxt_crst;
            tmr_req_ff <= nxt_tmr_req;
        end
    end

    // read mux; unmapped locations read zero
    logic [1:0] stat_ff, nxt_stat;
    logic [2:0] fault_ff, nxt_fault;

    always_comb begin
        unique case (rd_addr)
            ADDR_STATCTL: rd_data = {2'h0, stat_ff, 1'b0, fault_ff};
            ADDR_CHIP_ID: rd_data = {VENDOR_CODE, PART_CODE, REV_CODE};
            ADDR_CURRENT: rd_data = {1'b1, cur_ff};
            default:      rd_data = 8'h00;
        endcase
    end

    // millisecond enable and safety timer
    ccr_chg_e    chg_ff, nxt_chg;
    logic [14:0] div_ff, nxt_div;
    logic        tick_ff, nxt_tick;
    logic [20:0] safe_ff, nxt_safe;
    logic        exp_ff, nxt_exp;
    logic        timing, tmr_clr;

    assign timing  = chg_ff == CH_PRE || chg_ff == CH_FAST;
    assign tmr_clr = tmr_req_ff || crst_ff || !timing;

    always_comb begin
        nxt_div  = div_ff + 15'h1;
        nxt_tick = 1'b0;
        if (div_ff == 15'(MS_CYC - 1)) begin
            nxt_div  = 15'h0;
            nxt_tick = 1'b1;
        end
        nxt_safe = safe_ff;
        nxt_exp  = exp_ff;
        if (tmr_clr) begin
            nxt_safe = 21'h0;
            nxt_exp  = 1'b0;
        end else if (tick_ff && !exp_ff) begin
            nxt_safe = safe_ff + 21'h1;
            nxt_exp  = safe_ff == 21'(SAFE_MS - 1);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_ff  <= 15'h0;
            tick_ff <= 1'b0;
            safe_ff <= 21'h0;
            exp_ff  <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
            safe_ff <= nxt_safe;
            exp_ff  <= nxt_exp;
        end
    end

    // charge cycle
    logic on_ff, nxt_on;
    logic clamp_ff, nxt_clamp;
    logic dfct_ff, nxt_dfct;

    always_comb begin
        nxt_chg   = chg_ff;
        nxt_dfct  = dfct_ff;
        nxt_fault = fault_ff;
        if (crst_ff || !s2_ff.vin_good) begin
            nxt_chg   = CH_IDLE;
            nxt_dfct  = 1'b0;
            nxt_fault = FLT_NONE;
        end else begin
            unique case (chg_ff)
                CH_IDLE: nxt_chg = s2_ff.bat_low ? CH_PRE : CH_FAST;
                CH_PRE: begin
                    if (exp_ff) begin
                        nxt_chg   = CH_FAULT;
                        nxt_dfct  = 1'b1;
                        nxt_fault = FLT_TIMER;
                    end else if (!s2_ff.bat_low) begin
                        nxt_chg = CH_FAST;
                    end
                end
                CH_FAST: begin
                    if (exp_ff) begin
                        nxt_chg   = CH_FAULT;
                        nxt_fault = FLT_TIMER;
                    end else if (s2_ff.bat_low) begin
                        nxt_chg = CH_PRE;
                    end else if (s2_ff.term_hit) begin
                        nxt_chg = CH_DONE;
                    end
                end
                CH_DONE: begin
                    if (s2_ff.bat_refresh) begin
                        nxt_chg = s2_ff.bat_low ? CH_PRE : CH_FAST;
                    end
                end
                CH_FAULT: ;
                default: nxt_chg = CH_IDLE;
            endcase
        end
        nxt_on    = nxt_chg == CH_PRE || nxt_chg == CH_FAST;
        nxt_clamp = nxt_on && s2_ff.bat_short;
        unique case (nxt_chg)
            CH_PRE, CH_FAST: nxt_stat = STAT_CHARGE;
            CH_DONE:         nxt_stat = STAT_DONE;
            CH_FAULT:        nxt_stat = STAT_FAULT;
            default:         nxt_stat = STAT_READY;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chg_ff   <= CH_IDLE;
            on_ff    <= 1'b0;
            clamp_ff <= 1'b0;
            dfct_ff  <= 1'b0;
            stat_ff  <= STAT_READY;
            fault_ff <= FLT_NONE;
        end else begin
            chg_ff   <= nxt_chg;
            on_ff    <= nxt_on;
            clamp_ff <= nxt_clamp;
            dfct_ff  <= nxt_dfct;
            stat_ff  <= nxt_stat;
            fault_ff <= nxt_fault;
        end
    end

    // sense level outputs
    logic [9:0] fast_ff, nxt_fast;
    logic [9:0] end_ff, nxt_end;
    logic       sda_out_ff;

    always_comb begin
        nxt_fast = sense_level(FAST_BASE, FAST_STEP, cur_ff[FAST_LSB+:3]);
        nxt_end  = sense_level(END_BASE, END_STEP, cur_ff[END_LSB+:3]);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fast_ff    <= FAST_BASE;
            end_ff     <= END_BASE + END_STEP;
            sda_out_ff <= 1'b0;
        end else begin
            fast_ff    <= nxt_fast;
            end_ff     <= nxt_end;
            sda_out_ff <= 1'b0;
        end
    end

    assign sda_out           = sda_out_ff;
    assign sda_oe            = slv_oe;
    assign fast_sense_lvl    = fast_ff;
    assign end_sense_lvl     = end_ff;
    assign charge_on         = on_ff;
    assign short_clamp       = clamp_ff;
    assign charger_reset     = crst_ff;
    assign battery_defective = dfct_ff;
    assign charge_stat       = stat_ff;
endmodule
`default_nettype wire

// [core/ccr_pkg.sv]
package ccr_pkg;
    // register locations
    localparam logic [7:0] ADDR_STATCTL = 8'h00;
    localparam logic [7:0] ADDR_CHIP_ID = 8'h03;
    localparam logic [7:0] ADDR_CURRENT = 8'h04;
    // current register layout and reset value; status register timer restart bit
    localparam logic [7:0] CUR_RST      = 8'h89;
    localparam int         CUR_RESET_B  = 7;
    localparam int         FAST_LSB     = 4;
    localparam int         END_LSB      = 0;
    localparam int         TIMER_RESTART_B = 7;
    // sense levels in units of 0.1 mV: base plus step times the 3-bit code
    localparam logic [9:0] FAST_BASE    = 10'h176;
    localparam logic [9:0] FAST_STEP    = 10'h044;
    localparam logic [9:0] END_BASE     = 10'h022;
    localparam logic [9:0] END_STEP     = 10'h022;
    // timing
    localparam int         CLK_NS       = 50;
    localparam int         MS_NS        = 1000000;
    localparam int         MS_CYCLES    = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int         SAFETY_MS    = 1800000;
    // charge status and fault codes
    localparam logic [1:0] STAT_READY   = 2'h0;
    localparam logic [1:0] STAT_CHARGE  = 2'h1;
    localparam logic [1:0] STAT_DONE    = 2'h2;
    localparam logic [1:0] STAT_FAULT   = 2'h3;
    localparam logic [2:0] FLT_NONE     = 3'h0;
    localparam logic [2:0] FLT_TIMER    = 3'h6;

    typedef enum logic [2:0] {
        CH_IDLE, CH_PRE, CH_FAST, CH_DONE, CH_FAULT
    } ccr_chg_e;

    typedef enum logic [2:0] {
        IS_IDLE, IS_ADDR, IS_PTR, IS_WR, IS_ACK, IS_RD, IS_MACK
    } ccr_i2c_e;

    // comparator pins from the analog stage
    typedef struct packed {
        logic vin_good;
        logic bat_low;
        logic bat_short;
        logic term_hit;
        logic bat_refresh;
    } ccr_sense_s;

    typedef struct packed {
        logic       wr_stb;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } ccr_regbus_s;
endpackage

// [core/ccr_i2c_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module ccr_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h6a
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          sys_rst,
    // bus pins
    input  wire logic          scl_pin,
    input  wire logic          sda_pin,
    output logic               sda_oe,
    // register side
    input  wire logic [7:0]    rd_data,
    output logic [7:0]         rd_addr,
    output ccr_pkg::ccr_regbus_s bus
);
    import ccr_pkg::*;

    logic [2:0]  scl_ff, sda_ff;
    ccr_i2c_e    st_ff, nxt_st, aft_ff, nxt_aft;
    logic [7:0]  sh_ff, nxt_sh, ptr_ff, nxt_ptr;
    logic [3:0]  cnt_ff, nxt_cnt;
    logic        oe_ff, nxt_oe;
    ccr_regbus_s bus_ff, nxt_bus;
    logic        rise, fall, start, stop, sda_s;

    // stage 0 feeds stage 1 only; edges look at stages 1 and 2
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            scl_ff <= 3'h7;
            sda_ff <= 3'h7;
        end else begin
            scl_ff <= {scl_ff[1:0], scl_pin};
            sda_ff <= {sda_ff[1:0], sda_pin};
        end
    end

    assign sda_s = sda_ff[1];
    assign rise  = scl_ff[1] & ~scl_ff[2];
    assign fall  = ~scl_ff[1] & scl_ff[2];
    assign start = scl_ff[1] & scl_ff[2] & sda_ff[2] & ~sda_ff[1];
    assign stop  = scl_ff[1] & scl_ff[2] & ~sda_ff[2] & sda_ff[1];

    always_comb begin
        nxt_st  = st_ff;
        nxt_aft = aft_ff;
        nxt_sh  = sh_ff;
        nxt_ptr = ptr_ff;
        nxt_cnt = cnt_ff;
        nxt_oe  = oe_ff;
        nxt_bus = bus_ff;
        nxt_bus.wr_stb = 1'b0;
        if (start) begin
            nxt_st  = IS_ADDR;
            nxt_cnt = 4'h0;
            nxt_oe  = 1'b0;
        end else if (stop) begin
            nxt_st = IS_IDLE;
            nxt_oe = 1'b0;
        end else begin
            unique case (st_ff)
                IS_IDLE: ;
                IS_ADDR, IS_PTR, IS_WR: begin
                    if (rise && cnt_ff != 4'h8) begin
                        nxt_sh  = {sh_ff[6:0], sda_s};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (fall && cnt_ff == 4'h8) begin
                        nxt_cnt = 4'h0;
                        nxt_oe  = 1'b1;
                        nxt_st  = IS_ACK;
                        nxt_aft = IS_WR;
                        if (st_ff == IS_ADDR) begin
                            nxt_aft = sh_ff[0] ? IS_RD : IS_PTR;
                            if (sh_ff[7:1] != DEV_ADDR) begin
                                nxt_oe = 1'b0;
                                nxt_st = IS_IDLE;
                            end
                        end else if (st_ff == IS_PTR) begin
                            nxt_ptr = sh_ff;
                        end else begin
                            nxt_bus.wr_stb  = 1'b1;
                            nxt_bus.wr_addr = ptr_ff;
                            nxt_bus.wr_data = sh_ff;
                            nxt_ptr = ptr_ff + 8'h1;
                        end
                    end
                end
                IS_ACK: begin
                    if (fall) begin
                        nxt_oe = 1'b0;
                        nxt_st = aft_ff;
                        if (aft_ff == IS_RD) begin
                            nxt_sh  = rd_data;
                            nxt_oe  = ~rd_data[7];
                            nxt_cnt = 4'h1;
                        end
                    end
                end
                IS_RD: begin
                    if (fall) begin
                        if (cnt_ff == 4'h8) begin
                            nxt_oe  = 1'b0;
                            nxt_st  = IS_MACK;
                            nxt_ptr = ptr_ff + 8'h1;
                        end else begin
                            nxt_oe  = ~sh_ff[6];
                            nxt_sh  = {sh_ff[6:0], 1'b0};
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                    end
                end
                IS_MACK: begin
                    if (rise) begin
                        nxt_st  = sda_s ? IS_IDLE : IS_ACK;
                        nxt_aft = IS_RD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff  <= IS_IDLE;
            aft_ff <= IS_IDLE;
            sh_ff  <= 8'h00;
            ptr_ff <= 8'h00;
            cnt_ff <= 4'h0;
            oe_ff  <= 1'b0;
            bus_ff <= '0;
        end else begin
            st_ff  <= nxt_st;
            aft_ff <= nxt_aft;
            sh_ff  <= nxt_sh;
            ptr_ff <= nxt_ptr;
            cnt_ff <= nxt_cnt;
            oe_ff  <= nxt_oe;
            bus_ff <= nxt_bus;
        end
    end

    assign sda_oe  = oe_ff;
    assign rd_addr = ptr_ff;
    assign bus     = bus_ff;
endmodule
`default_nettype wire

// [sim/ccr_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ccr_top_sva #(
    parameter int unsigned MS_CYC  = 4,
    parameter int unsigned SAFE_MS = 5
) (
    // clock and reset
    input wire logic                clock,
    input wire logic                sys_rst,
    // serial bus pins
    input wire logic                scl_pin,
    input wire logic                sda_pin,
    input wire logic                sda_out,
    input wire logic                sda_oe,
    // comparators
    input wire ccr_pkg::ccr_sense_s sense_pin,
    // power stage controls
    input wire logic [9:0]          fast_sense_lvl,
    input wire logic [9:0]          end_sense_lvl,
    input wire logic                charge_on,
    input wire logic                short_clamp,
    input wire logic                charger_reset,
    input wire logic                battery_defective,
    input wire logic [1:0]          charge_stat
);
    import ccr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // battery done and refresh level seen on two samples
    sequence s_done_refresh;
        (charge_stat == STAT_DONE && sense_pin.bat_refresh && sense_pin.vin_good) [*2];
    endsequence
    sequence s_short_charging;
        (sense_pin.bat_short && charge_on) [*4];
    endsequence
    a_reset_one_cycle: assert property (charger_reset |=> !charger_reset)
        else $error("charger reset pulse too long");
    a_reset_defaults: assert property (charger_reset |-> ##[0:3]
        (fast_sense_lvl == FAST_BASE && end_sense_lvl == END_BASE + END_STEP &&
        !battery_defective))
        else $error("charger reset did not restore defaults");
    a_fast_grid: assert property (fast_sense_lvl >= FAST_BASE &&
        (fast_sense_lvl - FAST_BASE) % FAST_STEP == 0 &&
        fast_sense_lvl <= FAST_BASE + 7 * FAST_STEP)
        else $error("fast sense level off the grid");
    a_end_grid: assert property (end_sense_lvl >= END_BASE &&
        (end_sense_lvl - END_BASE) % END_STEP == 0 && end_sense_lvl <= END_BASE + 7 * END_STEP)
        else $error("termination sense level off the grid");
    a_clamp_follows: assert property (s_short_charging |-> short_clamp)
        else $error("short clamp missing");
    a_clamp_charging: assert property (short_clamp |-> charge_on)
        else $error("short clamp while not charging");
    a_refresh_restart: assert property (s_done_refresh |-> ##[1:4] charge_on)
        else $error("refresh did not restart charging");
    a_defect_fault: assert property (battery_defective |->
        charge_stat == STAT_FAULT && !charge_on)
        else $error("defective battery without fault stop");
    a_defect_rise: assert property ($rose(battery_defective) |-> $past(charge_on))
        else $error("defective mark outside charging");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_pin && !$past(scl_pin, 2))
        else $error("data line driven too early");
    a_oe_scl_high: assert property (scl_pin && $past(scl_pin) |-> $stable(sda_oe))
        else $error("data line changed while clock high");
endmodule
bind ccr_top ccr_top_sva #(.MS_CYC(MS_CYC), .SAFE_MS(SAFE_MS)) u_sva (
    .clock(clock), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_pin(sda_pin),
    .sda_out(sda_out), .sda_oe(sda_oe), .sense_pin(sense_pin),
    .fast_sense_lvl(fast_sense_lvl), .end_sense_lvl(end_sense_lvl), .charge_on(charge_on),
    .short_clamp(short_clamp), .charger_reset(charger_reset),
    .battery_defective(battery_defective), .charge_stat(charge_stat));
`default_nettype wire

// [sim/ccr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
    // clock
    input  wire logic clock,
    // bus pins
    input  wire logic dev_oe,
    output logic      scl,
    output logic      sda
);
    logic host_low;
    int   nak_cnt;
    // open-drain line with pull-up
    assign sda = !(host_low || dev_oe);
    initial begin
        scl = 1'b1;
        host_low = 1'b0;
        nak_cnt = 0;
    end
    task automatic hp();
        repeat (8) @(negedge clock);
    endtask
    task automatic start();
        host_low = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        host_low = 1'b1;
        hp();
        scl = 1'b0;
    endtask
    task automatic stop();
        host_low = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        host_low = 1'b0;
        hp();
    endtask
    task automatic bit_io(input logic b, output logic r);
        host_low = !b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        scl = 1'b0;
    endtask
    task automatic tx_byte(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        if (r !== 1'b0) nak_cnt++;
    endtask
    task automatic wr_reg(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d);
        start();
        tx_byte(dev);
        tx_byte(a);
        tx_byte(d);
        stop();
    endtask
    // single byte read, ended by a not-acknowledge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        logic r;
        start();
        tx_byte(8'hd4);
        tx_byte(a);
        start();
        tx_byte(8'hd5);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop();
    endtask
endmodule
`default_nettype wire

// [sim/ccr_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module ccr_top_test;
    import ccr_pkg::*;
    `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
        $display("wrong value at %0t got %h expected %h", $time, got, exp); end end
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    ccr_sense_s sense = '0;
    wire        scl;
    wire        sda;
    logic       sda_out, sda_oe, charge_on, short_clamp, charger_reset, battery_defective;
    logic [9:0] fast_sense_lvl, end_sense_lvl;
    logic [1:0] charge_stat;
    logic [7:0] v;
    logic [3:0] c;
    int         err_total = 0;
    int         tests_run = 0;
    int         pulses = 0;
    int         i;
    // identity values are arbitrary
    localparam logic [7:0] ID_EXP = {3'h5, 2'h1, 3'h2};
    always #25 clock = ~clock;
    always @(posedge clock) if (charger_reset === 1'b1) pulses++;
    ccr_top #(.VENDOR_CODE(3'h5), .PART_CODE(2'h1), .REV_CODE(3'h2),
        .MS_CYC(4), .SAFE_MS(300)) uut (
        .clock(clock), .sys_rst(sys_rst), .scl_pin(scl), .sda_pin(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .sense_pin(sense), .fast_sense_lvl(fast_sense_lvl),
        .end_sense_lvl(end_sense_lvl), .charge_on(charge_on), .short_clamp(short_clamp),
        .charger_reset(charger_reset), .battery_defective(battery_defective),
        .charge_stat(charge_stat));
    ccr_host_model m (.clock(clock), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        m.wr_reg(8'hd4, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        m.rd_reg(a, d);
        `CHK(d, exp)
        `CHK(sda_out, 1'b0)
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic end_sim();
        $display("tests_run %0d err_total %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        end_sim();
    end
    initial begin
        settle(6);
        sys_rst = 1'b0;
        settle(4);
        rd(ADDR_CURRENT, CUR_RST);
        `CHK(fast_sense_lvl, FAST_BASE)
        `CHK(end_sense_lvl, END_BASE + END_STEP)
        wr(ADDR_CHIP_ID, 8'h55);
        rd(ADDR_CHIP_ID, ID_EXP);
        rd(8'h05, 8'h00);
        m.wr_reg(8'hd6, ADDR_CURRENT, 8'h00);
        `CHK(m.nak_cnt, 3)
        rd(ADDR_CURRENT, CUR_RST);
        $display("test reset_and_id done");
        for (c = 0; c < 8; c++) begin
            v = {1'b0, c[2:0], c[0], ~c[2:0]};
            wr(ADDR_CURRENT, v);
            rd(ADDR_CURRENT, v | 8'h80);
            `CHK(fast_sense_lvl, FAST_BASE + FAST_STEP * c[2:0])
            `CHK(end_sense_lvl, END_BASE + END_STEP * v[2:0])
        end
        `CHK(pulses, 0)
        wr(ADDR_CURRENT, 8'hf6);
        `CHK(pulses, 1)
        rd(ADDR_CURRENT, CUR_RST);
        $display("test current_fields done");
        sense.vin_good = 1'b1;
        settle(8);
        `CHK(charge_stat, STAT_CHARGE)
        sense.bat_short = 1'b1;
        settle(8);
        `CHK(short_clamp, 1'b1)
        sense.bat_short = 1'b0;
        settle(8);
        `CHK(short_clamp, 1'b0)
        sense.term_hit = 1'b1;
        settle(8);
        `CHK(charge_stat, STAT_DONE)
        sense.term_hit = 1'b0;
        sense.bat_refresh = 1'b1;
        settle(8);
        `CHK(charge_on, 1'b1)
        sense.bat_refresh = 1'b0;
        settle(300);
        wr(ADDR_STATCTL, 8'h80);
        settle(600);
        `CHK(charge_on, 1'b1)
        for (i = 0; i < 1000 && charge_stat !== STAT_FAULT; i++) settle(1);
        `CHK(charge_stat, STAT_FAULT)
        `CHK(battery_defective, 1'b0)
        rd(ADDR_STATCTL, 8'h36);
        $display("test fast_charge_timer done");
        sense = '0;
        settle(8);
        sense.vin_good = 1'b1;
        sense.bat_low = 1'b1;
        for (i = 0; i < 1500 && battery_defective !== 1'b1; i++) settle(1);
        `CHK(battery_defective, 1'b1)
        `CHK(charge_on, 1'b0)
        wr(ADDR_CURRENT, 8'h80);
        `CHK(battery_defective, 1'b0)
        `CHK(m.nak_cnt, 3)
        $display("test precharge_timer done");
        wr(ADDR_CURRENT, 8'h7f);
        sys_rst = 1'b1;
        settle(2);
        sys_rst = 1'b0;
        settle(4);
        `CHK(fast_sense_lvl, FAST_BASE)
        `CHK(end_sense_lvl, END_BASE + END_STEP)
        rd(ADDR_CURRENT, CUR_RST);
        $display("test mid_reset done");
        end_sim();
    end
endmodule
`default_nettype wire
